// *** bench/lcd_host_model.sv ***
// host processor model issuing instruction and data bytes
// assumes the bench calls send from one process only
`timescale 1ns/1ps
module lcd_host_model
	import lcd_instr_pkg::*;
(
	input wire logic clk_i,
	output instr_t instr_o
);
	initial instr_o = '0;
	// one byte per call, launched off the falling edge, valid for one cycle
	task automatic send(input logic rs, input logic [7:0] byte_v);
		@(negedge clk_i);
		instr_o = '{1'b1, rs, 1'b0, byte_v};
		@(negedge clk_i);
		instr_o.valid = 1'b0;
		// released bus shows the inverse so a stale byte never looks valid
		instr_o.data = ~byte_v;
	endtask
endmodule

// *** bench/lcd_scroll_drive_ram_instr_monitor.sv ***
// assertions on the instruction block ports
// assumes one clock domain and the asynchronous active-high reset
`timescale 1ns/1ps
module lcd_scroll_drive_ram_instr_monitor
	import lcd_instr_pkg::*;
(
	input wire logic REF_CLK_I,
	input wire logic SYS_RST_I,
	input wire instr_t INSTR_I,
	input wire logic BANK_SEL_I,
	input wire logic ADDR_INC_I,
	input wire logic READ_HOLD_I,
	input wire logic SLEEP_I,
	input wire logic STANDBY_I,
	input wire logic RAM_READ_I,
	input wire logic [9:0] DBL_HEIGHT_O,
	input wire logic [3:0] START_LINE_O,
	input wire logic [1:0] FIXED_LINES_O,
	input wire logic BOOST_FAST_O,
	input wire logic [10:0] ADDRESS_COUNTER_O,
	input wire ram_wr_t RAM_WR_O,
	input wire logic BOOST_CLK_EN_O
);
	logic [6:0] gap_q;
	logic seen_q;
	logic chg_q;
	logic ins;
	logic wr;
	logic zz;
	assign zz = SLEEP_I | STANDBY_I;
	assign ins = INSTR_I.valid & ~INSTR_I.instr_data_select & ~INSTR_I.read_not_write;
	assign wr = INSTR_I.valid & INSTR_I.instr_data_select & ~INSTR_I.read_not_write;
	// --------------------------------
	// booster gap counter
	// --------------------------------
	// a select change inside a gap voids that gap, its length is not defined
	always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			gap_q <= 7'h00;
			seen_q <= 1'b0;
			chg_q <= 1'b0;
		end else begin
			gap_q <= BOOST_CLK_EN_O ? 7'h00 : gap_q + 7'h01;
			seen_q <= seen_q | BOOST_CLK_EN_O;
			chg_q <= BOOST_CLK_EN_O ? 1'b0 : (chg_q | $changed(BOOST_FAST_O));
		end
	end
	default clocking @(posedge REF_CLK_I); endclocking
	default disable iff (SYS_RST_I);
	// --------------------------------
	// properties
	// --------------------------------
	property p_dbl_low;
		ins && INSTR_I.data[7:3] == OP_DBL_HEIGHT && !BANK_SEL_I |=> DBL_HEIGHT_O[2:0] ==
		$past(INSTR_I.data[2:0]) && DBL_HEIGHT_O[9:3] == $past(DBL_HEIGHT_O[9:3]);
	endproperty
	a_dbl_low: assert property (p_dbl_low) else $error("low double-height bits wrong");
	property p_dbl_mid;
		ins && INSTR_I.data[7:3] == OP_DBL_HEIGHT && BANK_SEL_I |=> DBL_HEIGHT_O[5:3] ==
		$past(INSTR_I.data[2:0]) && DBL_HEIGHT_O[2:0] == $past(DBL_HEIGHT_O[2:0]);
	endproperty
	a_dbl_mid: assert property (p_dbl_mid) else $error("mid double-height bits wrong");
	property p_start_low;
		ins && INSTR_I.data[7:3] == OP_SCROLL_1 && !BANK_SEL_I |=>
		START_LINE_O == {$past(START_LINE_O[3]), $past(INSTR_I.data[2:0])};
	endproperty
	a_start_low: assert property (p_start_low) else $error("start line low part wrong");
	property p_fixed;
		ins && INSTR_I.data[7:3] == OP_SCROLL_2 && BANK_SEL_I |=>
		FIXED_LINES_O == $past(INSTR_I.data[1:0]);
	endproperty
	a_fixed: assert property (p_fixed) else $error("fixed line field wrong");
	property p_addr_high;
		ins && INSTR_I.data[7:5] == OP_ADDR_HIGH && !zz |=>
		ADDRESS_COUNTER_O == {$past(INSTR_I.data[4:0]), $past(ADDRESS_COUNTER_O[5:0])};
	endproperty
	a_addr_high: assert property (p_addr_high) else $error("address high byte wrong");
	property p_write;
		wr && !zz && !RAM_READ_I |=> RAM_WR_O.we && RAM_WR_O.addr == $past(ADDRESS_COUNTER_O)
		&& RAM_WR_O.wdata == $past(INSTR_I.data) && ADDRESS_COUNTER_O ==
		$past(ADDRESS_COUNTER_O) + ($past(ADDR_INC_I) ? 11'h001 : 11'h7ff);
	endproperty
	a_write: assert property (p_write) else $error("ram write or step wrong");
	property p_asleep;
		(wr || RAM_READ_I) && zz |=> !RAM_WR_O.we && $stable(ADDRESS_COUNTER_O);
	endproperty
	a_asleep: assert property (p_asleep) else $error("ram access while asleep");
	property p_hold;
		RAM_READ_I && READ_HOLD_I && !INSTR_I.valid |=> $stable(ADDRESS_COUNTER_O);
	endproperty
	a_hold: assert property (p_hold) else $error("held read moved counter");
	property p_boost;
		BOOST_CLK_EN_O && seen_q && !chg_q && !$changed(BOOST_FAST_O) |->
		gap_q == (BOOST_FAST_O ? 7'h1f : 7'h3f);
	endproperty
	a_boost: assert property (p_boost) else $error("booster pulse spacing wrong");
	c_write: cover property (wr && !zz);
	c_fast: cover property (BOOST_CLK_EN_O && BOOST_FAST_O);
	c_hold: cover property (RAM_READ_I && READ_HOLD_I);
endmodule
bind lcd_scroll_drive_ram_instr lcd_scroll_drive_ram_instr_monitor u_mon (
	.REF_CLK_I(REF_CLK_I), .SYS_RST_I(SYS_RST_I), .INSTR_I(INSTR_I), .BANK_SEL_I(BANK_SEL_I),
	.ADDR_INC_I(ADDR_INC_I), .READ_HOLD_I(READ_HOLD_I), .SLEEP_I(SLEEP_I),
	.STANDBY_I(STANDBY_I), .RAM_READ_I(RAM_READ_I), .DBL_HEIGHT_O(DBL_HEIGHT_O),
	.START_LINE_O(START_LINE_O), .FIXED_LINES_O(FIXED_LINES_O), .BOOST_FAST_O(BOOST_FAST_O),
	.ADDRESS_COUNTER_O(ADDRESS_COUNTER_O), .RAM_WR_O(RAM_WR_O),
	.BOOST_CLK_EN_O(BOOST_CLK_EN_O));

// *** bench/test_lcd_scroll_drive_ram_instr.sv ***
// self-checking bench for the instruction block
// assumes the host model and the bound checker
`timescale 1ns/1ps
module test_lcd_scroll_drive_ram_instr;
	import lcd_instr_pkg::*;
	typedef struct packed {logic bk; logic [7:0] op; logic [2:0] sel; logic [9:0] exp;} row_t;
	logic clk, rst, bank, inc, hold, slp, stb, rd, fs, rt, on_v, rp, bf, xe, en, pol, sdbl;
	logic [9:0] dbl;
	logic [3:0] sl, line;
	logic [2:0] sr, rast;
	logic [1:0] fx;
	logic [4:0] alt;
	logic [10:0] acnt;
	ram_wr_t wr;
	instr_t bus;
	int n_mismatch = 0, n_tests = 0, cyc = 0, n;
	row_t rows[14] = '{
		'{1'b0, 8'h45, 3'h0, 10'h005}, '{1'b1, 8'h46, 3'h0, 10'h035},
		'{1'b0, 8'h36, 3'h0, 10'h235}, '{1'b1, 8'h35, 3'h0, 10'h375},
		'{1'b0, 8'h49, 3'h1, 10'h001}, '{1'b1, 8'h49, 3'h1, 10'h009},
		'{1'b0, 8'h57, 3'h2, 10'h007}, '{1'b1, 8'h53, 3'h3, 10'h003},
		'{1'b0, 8'h73, 3'h4, 10'h000}, '{1'b1, 8'h73, 3'h4, 10'h006},
		'{1'b0, 8'h7d, 3'h5, 10'h005}, '{1'b1, 8'h7f, 3'h5, 10'h01d},
		'{1'b1, 8'h7f, 3'h4, 10'h007}, '{1'b1, 8'h50, 3'h3, 10'h000}};
	lcd_host_model u_host (.clk_i(clk), .instr_o(bus));
	lcd_scroll_drive_ram_instr u_dut (.REF_CLK_I(clk), .SYS_RST_I(rst), .INSTR_I(bus),
		.BANK_SEL_I(bank), .ADDR_INC_I(inc), .READ_HOLD_I(hold), .SLEEP_I(slp),
		.STANDBY_I(stb), .RAM_READ_I(rd), .FRAME_START_I(fs), .ROW_TICK_I(rt),
		.DBL_HEIGHT_O(dbl), .DISPLAY_ON_O(on_v), .START_LINE_O(sl), .START_RASTER_O(sr),
		.FIXED_LINES_O(fx), .ROW_PATTERN_O(rp), .BOOST_FAST_O(bf), .XOR_ENABLE_O(xe),
		.ALT_ROWS_O(alt), .ADDRESS_COUNTER_O(acnt), .RAM_WR_O(wr), .BOOST_CLK_EN_O(en),
		.DRIVE_POLARITY_O(pol), .SCAN_LINE_O(line), .SCAN_RASTER_O(rast), .SCAN_DOUBLE_O(sdbl));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	function automatic logic [9:0] pick(input logic [2:0] s);
		case (s)
			3'h0: pick = dbl;
			3'h1: pick = {6'h00, sl};
			3'h2: pick = {7'h00, sr};
			3'h3: pick = {8'h00, fx};
			3'h4: pick = {7'h00, rp, bf, xe};
			default: pick = {5'h00, alt};
		endcase
	endfunction
	task automatic wchk(input logic [7:0] d, input logic [10:0] a, input logic [10:0] nxt);
		u_host.send(1'b1, d);
		chk("write strobe", {wr.we, wr.wdata}, {1'b1, d});
		chk("write address", wr.addr, a);
		chk("counter step", acnt, nxt);
	endtask
	task automatic pulse(ref logic s);
		@(negedge clk);
		s = 1'b1;
		@(negedge clk);
		s = 1'b0;
		repeat (2) @(negedge clk);
	endtask
	// spacing between booster pulses, bounded so a dead counter cannot hang
	task automatic boost_gap(output int g);
		g = 0;
		while (en !== 1'b1 && g < 200) begin
			@(posedge clk);
			#1 g++;
		end
		g = 0;
		do begin
			@(posedge clk);
			#1 g++;
		end while (en !== 1'b1 && g < 200);
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_mismatch++;
			summarize();
		end
	end
	initial begin
		{rst, bank, inc, hold, slp, stb, rd, fs, rt} = 9'h100;
		inc = 1'b1;
		repeat (20) @(posedge clk);
		@(negedge clk) rst = 1'b0;
		chk("reset regs", {dbl, on_v, rp, bf, xe, fx}, 16'h0000);
		chk("reset more", {acnt, alt}, 16'h0000);
		chk("reset line", {sl, sr, wr.we}, 16'h0000);
		foreach (rows[i]) begin
			@(negedge clk) bank = rows[i].bk;
			u_host.send(1'b0, rows[i].op);
			chk("table row", pick(rows[i].sel), rows[i].exp);
		end
		u_host.send(1'b0, 8'ha3);
		u_host.send(1'b0, 8'hc5);
		chk("address set", acnt, 16'h00c5);
		wchk(8'h5a, 11'h0c5, 11'h0c6);
		wchk(8'ha5, 11'h0c6, 11'h0c7);
		@(negedge clk) inc = 1'b0;
		wchk(8'h3c, 11'h0c7, 11'h0c6);
		u_host.send(1'b0, 8'ha0);
		u_host.send(1'b0, 8'hc0);
		wchk(8'hff, 11'h000, 11'h7ff);
		@(negedge clk) inc = 1'b1;
		pulse(rd);
		chk("read step", acnt, 16'h0000);
		@(negedge clk) hold = 1'b1;
		pulse(rd);
		chk("read hold", acnt, 16'h0000);
		// no address set is issued while asleep
		@(negedge clk) slp = 1'b1;
		u_host.send(1'b1, 8'h77);
		chk("sleep write", {wr.we, acnt}, 16'h0000);
		@(negedge clk) {slp, stb} = 2'b01;
		u_host.send(1'b1, 8'h78);
		chk("standby write", {wr.we, acnt}, 16'h0000);
		@(negedge clk) stb = 1'b0;
		boost_gap(n);
		chk("fast gap", n[15:0], 16'h0020);
		u_host.send(1'b0, 8'h71);
		boost_gap(n);
		boost_gap(n);
		chk("slow gap", n[15:0], 16'h0040);
		pulse(fs);
		chk("scan top", {line, rast}, 16'h004f);
		pulse(rt);
		chk("scan wrap", {line, rast}, 16'h0000);
		u_host.send(1'b0, 8'h51);
		pulse(fs);
		chk("fixed top", {line, rast}, 16'h0000);
		repeat (8) pulse(rt);
		chk("after fixed", {line, rast}, 16'h004f);
		// row pattern, no xor, period of two rows
		@(negedge clk) bank = 1'b1;
		u_host.send(1'b0, 8'h78);
		@(negedge clk) bank = 1'b0;
		u_host.send(1'b0, 8'h79);
		pulse(rt);
		chk("row pol first", pol, 1'b1);
		pulse(rt);
		chk("row pol hold", pol, 1'b1);
		pulse(rt);
		chk("row pol flip", pol, 1'b0);
		@(negedge clk) bank = 1'b1;
		u_host.send(1'b0, 8'h70);
		pulse(fs);
		chk("frame pol", pol, 1'b1);
		summarize();
	end
endmodule

// *** pkg/lcd_instr_pkg.sv ***
// constants and carrier types for the scroll, drive-pattern and bitmap ram instruction block
// assumes one operating clock shared with the instruction source
//
// How it works
// - bank selector 0: double-height opcode bits 2..0 enable lines one to three
// - bank selector 1: the same bits enable lines four to six
// - every display line has its own double-height flag, any mix allowed
// - lines seven to ten are doubled from the display-on/off opcode fields
// - start-line code: low three bits at bank 0, top bit at bank 1
// - start-line code n selects line n+1; codes above 1001 are unused
// - ten lines shown in order from the start line, wrapping ten to one
// - with fixed lines, start line applies to the first line after them
// - three-bit start raster picks which of eight rows shows first
// - fixed-line field at bank 1: 01, 10, 11 hold one, two, three lines
// - bank 1 pattern bit: 0 flips each frame, 1 flips every n rows
// - bank 1 booster select: 0 divides clock by 64, 1 by 32
// - row pattern with xor enable: frame parity xor row reversal
// - row pattern inverts every row count plus one rows, 1 to 32
// - row count: low three bits at bank 0, upper two at bank 1
// - address set in two bytes: bits 10..6 then bits 5..0
// - each ram byte write steps the address counter by one per direction
// - ram read steps the counter unless read-hold is set
// - no bitmap ram access in sleep or standby
// - each eight-row group uses 112 bytes from a multiple of 0x80
// - data-phase write stores the whole byte at the address counter
// - bank selector comes from the contrast opcode and picks the field set
package lcd_instr_pkg;

	typedef struct packed {
		logic valid;
		logic instr_data_select;
		logic read_not_write;
		logic [7:0] data;
	} instr_t;

	typedef struct packed {
		logic we;
		logic [10:0] addr;
		logic [7:0] wdata;
	} ram_wr_t;

	// opcode prefixes on data bits 7..3 (7..5 and 7..6 for address set)
	localparam logic [4:0] OP_DISP_ONOFF = 5'h06;
	localparam logic [4:0] OP_DBL_HEIGHT = 5'h08;
	localparam logic [4:0] OP_SCROLL_1 = 5'h09;
	localparam logic [4:0] OP_SCROLL_2 = 5'h0a;
	localparam logic [4:0] OP_PATTERN = 5'h0e;
	localparam logic [4:0] OP_WAVEFORM = 5'h0f;
	localparam logic [2:0] OP_ADDR_HIGH = 3'h5;
	localparam logic [1:0] OP_ADDR_LOW = 2'h3;

	localparam int LINE_COUNT = 10;
	localparam int RASTERS_PER_LINE = 8;
	localparam int SCAN_ROWS = 80;
	localparam int GROUP_STRIDE = 128;
	localparam int GROUP_BYTES = 112;
	localparam logic [3:0] LAST_LINE_CODE = 4'h9;

	localparam int BOOST_DIV_SLOW = 64;
	localparam int BOOST_DIV_FAST = 32;

	localparam logic [9:0] RST_DBL_HEIGHT = 10'h000;
	localparam logic [3:0] RST_START_LINE = 4'h0;
	localparam logic [2:0] RST_START_RASTER = 3'h0;
	localparam logic [1:0] RST_FIXED_LINES = 2'h0;
	localparam logic RST_ROW_PATTERN = 1'b0;
	localparam logic RST_BOOST_FAST = 1'b0;
	localparam logic RST_XOR_ENABLE = 1'b0;
	localparam logic [4:0] RST_ALT_ROWS = 5'h00;
	localparam logic [10:0] RST_ADDRESS = 11'h000;
	localparam logic RST_DISPLAY_ON = 1'b0;

endpackage

// *** verilog/lcd_scroll_drive_ram_instr.sv ***
// instruction decode and control registers for scroll, double height, drive pattern,
// booster clock and bitmap ram writes
// assumes instructions arrive as one-cycle strobes on the operating clock; the
// bank selector, direction, read-hold, sleep and standby levels come from other
// instruction decoders on the same clock
`timescale 1ns/1ps

module lcd_scroll_drive_ram_instr
	import lcd_instr_pkg::*;
(
	input wire logic REF_CLK_I,
	input wire logic SYS_RST_I,
	input wire instr_t INSTR_I,
	input wire logic BANK_SEL_I,
	input wire logic ADDR_INC_I,
	input wire logic READ_HOLD_I,
	input wire logic SLEEP_I,
	input wire logic STANDBY_I,
	input wire logic RAM_READ_I,
	input wire logic FRAME_START_I,
	input wire logic ROW_TICK_I,
	output logic [9:0] DBL_HEIGHT_O,
	output logic DISPLAY_ON_O,
	output logic [3:0] START_LINE_O,
	output logic [2:0] START_RASTER_O,
	output logic [1:0] FIXED_LINES_O,
	output logic ROW_PATTERN_O,
	output logic BOOST_FAST_O,
	output logic XOR_ENABLE_O,
	output logic [4:0] ALT_ROWS_O,
	output logic [10:0] ADDRESS_COUNTER_O,
	output ram_wr_t RAM_WR_O,
	output logic BOOST_CLK_EN_O,
	output logic DRIVE_POLARITY_O,
	output logic [3:0] SCAN_LINE_O,
	output logic [2:0] SCAN_RASTER_O,
	output logic SCAN_DOUBLE_O
);

	// ------------------------------------------------------------
	// decode
	// ------------------------------------------------------------
	logic cmd_wr;
	logic data_wr;
	logic ram_blocked;
	logic [4:0] op;

	assign op = INSTR_I.data[7:3];
	assign cmd_wr = INSTR_I.valid && !INSTR_I.instr_data_select && !INSTR_I.read_not_write;
	assign data_wr = INSTR_I.valid && INSTR_I.instr_data_select && !INSTR_I.read_not_write;
	assign ram_blocked = SLEEP_I || STANDBY_I;

	// ------------------------------------------------------------
	// double height and display on
	// ------------------------------------------------------------
	logic [9:0] dbl_height_q;
	logic display_on_q;

	always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			dbl_height_q <= RST_DBL_HEIGHT;
			display_on_q <= RST_DISPLAY_ON;
		end else if (cmd_wr && op == OP_DBL_HEIGHT) begin
			// one flag per line, so any set of lines can be doubled together
			if (!BANK_SEL_I) begin
				dbl_height_q[2:0] <= INSTR_I.data[2:0];
			end else begin
				dbl_height_q[5:3] <= INSTR_I.data[2:0];
			end
		end else if (cmd_wr && op == OP_DISP_ONOFF) begin
			if (!BANK_SEL_I) begin
				display_on_q <= INSTR_I.data[2];
				dbl_height_q[9] <= INSTR_I.data[1];
			end else begin
				dbl_height_q[8:6] <= INSTR_I.data[2:0];
			end
		end
	end

	// ------------------------------------------------------------
	// vertical scroll
	// ------------------------------------------------------------
	logic [3:0] start_line_q;
	logic [2:0] start_raster_q;
	logic [1:0] fixed_lines_q;

	always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			start_line_q <= RST_START_LINE;
			start_raster_q <= RST_START_RASTER;
			fixed_lines_q <= RST_FIXED_LINES;
		end else if (cmd_wr && op == OP_SCROLL_1) begin
			if (!BANK_SEL_I) begin
				start_line_q[2:0] <= INSTR_I.data[2:0];
			end else begin
				start_line_q[3] <= INSTR_I.data[0];
			end
		end else if (cmd_wr && op == OP_SCROLL_2) begin
			if (!BANK_SEL_I) begin
				start_raster_q <= INSTR_I.data[2:0];
			end else begin
				fixed_lines_q <= INSTR_I.data[1:0];
			end
		end
	end

	// ------------------------------------------------------------
	// drive pattern, booster clock, row alternation
	// ------------------------------------------------------------
	logic row_pattern_q;
	logic boost_fast_q;
	logic xor_enable_q;
	logic [4:0] alt_rows_q;

	always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			row_pattern_q <= RST_ROW_PATTERN;
			boost_fast_q <= RST_BOOST_FAST;
		end else if (cmd_wr && op == OP_PATTERN && INSTR_I.data[2] == 1'b0 && BANK_SEL_I) begin
			// the opcode only carries these fields at bank 1; bank 0 writes are dropped
			row_pattern_q <= INSTR_I.data[0];
			boost_fast_q <= INSTR_I.data[1];
		end
	end

	always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			xor_enable_q <= RST_XOR_ENABLE;
			alt_rows_q <= RST_ALT_ROWS;
		end else if (cmd_wr && op == OP_WAVEFORM) begin
			if (!BANK_SEL_I) begin
				alt_rows_q[2:0] <= INSTR_I.data[2:0];
			end else begin
				xor_enable_q <= INSTR_I.data[2];
				alt_rows_q[4:3] <= INSTR_I.data[1:0];
			end
		end
	end

	// ------------------------------------------------------------
	// booster clock enable
	// ------------------------------------------------------------
	localparam logic [5:0] BOOST_LAST_SLOW = 6'(BOOST_DIV_SLOW - 1);
	localparam logic [5:0] BOOST_LAST_FAST = 6'(BOOST_DIV_FAST - 1);
	logic [5:0] boost_cnt_q;
	logic boost_wrap;

	assign boost_wrap = boost_cnt_q == (boost_fast_q ? BOOST_LAST_FAST : BOOST_LAST_SLOW);

	always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			boost_cnt_q <= 6'h00;
			BOOST_CLK_EN_O <= 1'b0;
		end else begin
			// switching rate mid-count may give one long period; harmless for a pump
			boost_cnt_q <= (boost_wrap || boost_cnt_q > BOOST_LAST_FAST && boost_fast_q) ?
				6'h00 : boost_cnt_q + 6'h01;
			BOOST_CLK_EN_O <= boost_wrap;
		end
	end

	// ------------------------------------------------------------
	// ac polarity
	// ------------------------------------------------------------
	logic frame_odd_q;
	logic row_pol_q;
	logic [4:0] row_cnt_q;

	always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			frame_odd_q <= 1'b0;
		end else if (FRAME_START_I) begin
			frame_odd_q <= !frame_odd_q;
		end
	end

	always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			row_pol_q <= 1'b0;
			row_cnt_q <= 5'h00;
		end else if (ROW_TICK_I) begin
			if (row_cnt_q >= alt_rows_q) begin
				row_cnt_q <= 5'h00;
				row_pol_q <= !row_pol_q;
			end else begin
				row_cnt_q <= row_cnt_q + 5'h01;
			end
		end
	end

	always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			DRIVE_POLARITY_O <= 1'b0;
		end else if (!row_pattern_q) begin
			DRIVE_POLARITY_O <= frame_odd_q;
		end else if (xor_enable_q) begin
			DRIVE_POLARITY_O <= frame_odd_q ^ row_pol_q;
		end else begin
			DRIVE_POLARITY_O <= row_pol_q;
		end
	end

	// ------------------------------------------------------------
	// scan position to bitmap line
	// ------------------------------------------------------------
	logic [6:0] scan_row_q;
	logic [6:0] fixed_rows;
	logic [6:0] scroll_off;
	logic [3:0] start_eff;
	logic [4:0] line_sum;
	logic [3:0] line_d;
	logic [2:0] raster_d;

	always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			scan_row_q <= 7'h00;
		end else if (FRAME_START_I) begin
			scan_row_q <= 7'h00;
		end else if (ROW_TICK_I && scan_row_q != 7'(SCAN_ROWS - 1)) begin
			scan_row_q <= scan_row_q + 7'h01;
		end
	end

	always_comb begin
		fixed_rows = 7'({fixed_lines_q, 3'b000});
		// unused codes fall back to line one rather than reading outside the map
		start_eff = (start_line_q > LAST_LINE_CODE) ? 4'h0 : start_line_q;
		scroll_off = scan_row_q - fixed_rows + 7'(start_raster_q);
		if (scan_row_q < fixed_rows) begin
			line_sum = 5'(scan_row_q[6:3]);
			raster_d = scan_row_q[2:0];
		end else begin
			line_sum = 5'(start_eff) + 5'(scroll_off[6:3]);
			raster_d = scroll_off[2:0];
		end
		if (line_sum >= 5'(2 * LINE_COUNT)) begin
			line_d = 4'(line_sum - 5'(2 * LINE_COUNT));
		end else if (line_sum >= 5'(LINE_COUNT)) begin
			line_d = 4'(line_sum - 5'(LINE_COUNT));
		end else begin
			line_d = line_sum[3:0];
		end
	end

	always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			SCAN_LINE_O <= 4'h0;
			SCAN_RASTER_O <= 3'h0;
			SCAN_DOUBLE_O <= 1'b0;
		end else begin
			SCAN_LINE_O <= line_d;
			SCAN_RASTER_O <= raster_d;
			SCAN_DOUBLE_O <= dbl_height_q[line_d];
		end
	end

	// ------------------------------------------------------------
	// address counter and ram write
	// ------------------------------------------------------------
	logic [10:0] addr_q;
	logic [10:0] addr_step;
	logic step_now;

	assign addr_step = ADDR_INC_I ? addr_q + 11'h001 : addr_q - 11'h001;
	// reads step only without read-hold so read-modify-write lands on the same byte
	assign step_now = !ram_blocked && (data_wr || (RAM_READ_I && !READ_HOLD_I));

	always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			addr_q <= RST_ADDRESS;
		end else if (cmd_wr && !ram_blocked && INSTR_I.data[7:5] == OP_ADDR_HIGH) begin
			addr_q[10:6] <= INSTR_I.data[4:0];
		end else if (cmd_wr && !ram_blocked && INSTR_I.data[7:6] == OP_ADDR_LOW) begin
			addr_q[5:0] <= INSTR_I.data[5:0];
		end else if (step_now) begin
			addr_q <= addr_step;
		end
	end

	always_ff @(posedge REF_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			RAM_WR_O <= '0;
		end else begin
			// the counter is not range checked; addresses 0x70..0x7f of each group
			// fall in the gap of the 0x80 stride and hold nothing shown
			RAM_WR_O.we <= data_wr && !ram_blocked;
			RAM_WR_O.addr <= addr_q;
			RAM_WR_O.wdata <= INSTR_I.data;
		end
	end

	assign DBL_HEIGHT_O = dbl_height_q;
	assign DISPLAY_ON_O = display_on_q;
	assign START_LINE_O = start_line_q;
	assign START_RASTER_O = start_raster_q;
	assign FIXED_LINES_O = fixed_lines_q;
	assign ROW_PATTERN_O = row_pattern_q;
	assign BOOST_FAST_O = boost_fast_q;
	assign XOR_ENABLE_O = xor_enable_q;
	assign ALT_ROWS_O = alt_rows_q;
	assign ADDRESS_COUNTER_O = addr_q;

endmodule
